// File: design/swrsc_consts.svh
`ifndef SWRSC_CONSTS_SVH
`define SWRSC_CONSTS_SVH
// Register byte addresses
`define SWRSC_A_SWCTL 12'h404
`define SWRSC_A_ULSTS 12'h050
`define SWRSC_A_DLSTS 12'h054
`define SWRSC_A_WAKE 12'h5CC
`define SWRSC_A_GALT 12'h600
`define SWRSC_A_GDIR 12'h604
`define SWRSC_A_GOUT 12'h608
`define SWRSC_A_GIN 12'h60C
`define SWRSC_A_PRST 12'h610
`define SWRSC_A_GPE 12'h614
`define SWRSC_A_ISTAT 12'h618
`define SWRSC_A_IMASK 12'h61C
`define SWRSC_A_MBUS 12'h620
`define SWRSC_A_STAT 12'h624
// Field positions
`define SWRSC_B_HOLD 0
`define SWRSC_B_WDIR 0
`define SWRSC_B_WDRV 1
`define SWRSC_B_MCLK 0
`define SWRSC_B_MDAT 1
// Pin slots: 0=pin0 1=pin1 2=pin2 3=pin7 4=pin9
`define SWRSC_G_P2 0
`define SWRSC_G_P4 1
`define SWRSC_G_EXP 2
`define SWRSC_G_GPE 3
`define SWRSC_G_P3 4
// Interrupt status bits
`define SWRSC_I_EXP 0
`define SWRSC_I_HOLD 1
`define SWRSC_I_WAKE 2
`define SWRSC_I_APWR 3
// Mode codes
`define SWRSC_MODE_NORM 3'h0
`define SWRSC_MODE_EEP 3'h1
// Reset procedure time
`define SWRSC_CLK_NS 40
`define SWRSC_RSTPROC_NS 1000
`define SWRSC_RSTPROC_CYC ((`SWRSC_RSTPROC_NS + `SWRSC_CLK_NS - 1) / `SWRSC_CLK_NS)
`endif

// File: design/swrsc_pkg.sv
package swrsc_pkg;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        SWRSC_RST = 4'h1,
        SWRSC_INIT = 4'h2,
        SWRSC_HOLD = 4'h4,
        SWRSC_RUN = 4'h8
    } swrsc_state_e;
    typedef logic [31:0] swrsc_word_t;
endpackage

// File: design/swrsc_top.sv
`include "swrsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module swrsc_top #(
    parameter int NGPIO = 5,
    parameter int NDS = 3,
    parameter int RSTCYC = `SWRSC_RSTPROC_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_fundamental_reset_n,
    input wire logic i_reset_hold_strap,
    input wire logic [2:0] i_operating_mode_straps,
    input wire logic i_downstream_common_clock_strap,
    input wire logic i_upstream_common_clock_strap,
    input wire logic i_aux_power_disable_n,
    input wire logic i_ref_clock_pos,
    input wire logic i_ref_clock_neg,
    input wire logic i_wake_pin_n,
    output logic o_wake_pin_n,
    output logic o_wake_pin_oe,
    input wire logic [NGPIO-1:0] i_gpio,
    output logic [NGPIO-1:0] o_gpio,
    output logic [NGPIO-1:0] o_gpio_oe,
    input wire logic i_mgmt_bus_clock,
    output logic o_mgmt_bus_clock,
    output logic o_mgmt_bus_clock_oe,
    input wire logic i_mgmt_bus_data,
    output logic o_mgmt_bus_data,
    output logic o_mgmt_bus_data_oe,
    input wire logic [11:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_irq,
    output logic o_core_reset,
    output logic o_link_fund_reset,
    output logic o_aux_power_en,
    output logic o_pll_ref_valid,
    output logic o_eeprom_load_req,
    output logic o_mode_reserved
);
    // Sequencer state and reset procedure timer
    swrsc_pkg::swrsc_state_e state_reg;
    logic [15:0] cnt_reg;
    // Captured straps
    logic hold_strap_reg;
    logic [2:0] mode_reg;
    // Software registers
    logic hold_bit_reg;
    logic ulsts_reg;
    logic [NDS-1:0] dlsts_reg;
    logic [1:0] wake_reg;
    logic [NGPIO-1:0] galt_reg, gdir_reg, gout_reg;
    logic [NDS-1:0] prst_reg;
    logic gpe_reg;
    logic [3:0] istat_reg, imask_reg;
    logic [1:0] mbus_reg;
    // Previous samples for edge detection
    logic exp_prev_reg, wake_prev_reg, apwr_prev_reg;
    // Decoded strobes and events
    logic in_rst, wr_ok, fund_edge;
    logic [3:0] ev;
    logic exp_in, wake_in;

    // Fundamental reset is asserted at logic zero
    assign in_rst = ~i_fundamental_reset_n;
    // Writes land only once reset procedure is over
    assign wr_ok = i_reg_wr & (state_reg[2] | state_reg[3]);
    // Release edge of the fundamental reset
    assign fund_edge = state_reg[0] & i_fundamental_reset_n;
    // Expander input only counts in its alternate role
    assign exp_in = galt_reg[`SWRSC_G_EXP] & ~i_gpio[`SWRSC_G_EXP];
    // Wake pin is an input only when not driving
    assign wake_in = ~wake_reg[`SWRSC_B_WDIR] & ~i_wake_pin_n;

    // Events: rising edges of the watched levels; hold marks the end of init with the hold strap set
    always_comb begin
        ev = 4'h0;
        ev[`SWRSC_I_EXP] = exp_in & ~exp_prev_reg;
        ev[`SWRSC_I_HOLD] = state_reg[1] & (cnt_reg == 16'h0000) & hold_strap_reg;
        ev[`SWRSC_I_WAKE] = wake_in & ~wake_prev_reg;
        ev[`SWRSC_I_APWR] = ~i_aux_power_disable_n & apwr_prev_reg;
    end

    // Reset sequencer
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= swrsc_pkg::SWRSC_RST;
            cnt_reg <= 16'h0000;
        end else if (i_clk_en) begin
            if (in_rst) begin
                // Reset wins from any state
                state_reg <= swrsc_pkg::SWRSC_RST;
                cnt_reg <= 16'(RSTCYC);
            end else begin
                case (state_reg)
                    swrsc_pkg::SWRSC_RST: begin
                        state_reg <= swrsc_pkg::SWRSC_INIT;
                        cnt_reg <= 16'(RSTCYC);
                    end
                    swrsc_pkg::SWRSC_INIT: begin
                        // Run reset procedure, then maybe hold
                        if (cnt_reg == 16'h0000) begin
                            state_reg <= hold_strap_reg ? swrsc_pkg::SWRSC_HOLD
                                                        : swrsc_pkg::SWRSC_RUN;
                        end else begin
                            cnt_reg <= cnt_reg - 16'h0001;
                        end
                    end
                    swrsc_pkg::SWRSC_HOLD: begin
                        // Leave once the hold bit is cleared
                        if (!hold_bit_reg) begin
                            state_reg <= swrsc_pkg::SWRSC_RUN;
                        end
                    end
                    swrsc_pkg::SWRSC_RUN: begin
                        state_reg <= swrsc_pkg::SWRSC_RUN;
                    end
                    default: begin
                        state_reg <= swrsc_pkg::SWRSC_RST;
                    end
                endcase
            end
        end
    end

    // Strap capture on the release edge only
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_strap_reg <= 1'b0;
            mode_reg <= `SWRSC_MODE_NORM;
        end else if (i_clk_en && fund_edge) begin
            // Held for the rest of operation
            hold_strap_reg <= i_reset_hold_strap;
            mode_reg <= i_operating_mode_straps;
        end
    end

    // Control registers; fundamental reset restores defaults
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_bit_reg <= 1'b0;
            ulsts_reg <= 1'b0;
            dlsts_reg <= '0;
            wake_reg <= 2'h0;
            galt_reg <= '0;
            gdir_reg <= '0;
            gout_reg <= '0;
            prst_reg <= '0;
            gpe_reg <= 1'b0;
            imask_reg <= 4'h0;
            mbus_reg <= 2'h0;
        end else if (i_clk_en) begin
            if (in_rst || fund_edge) begin
                // Defaults; clock bits reseeded from straps
                hold_bit_reg <= i_reset_hold_strap;
                ulsts_reg <= i_upstream_common_clock_strap;
                dlsts_reg <= {NDS{i_downstream_common_clock_strap}};
                wake_reg <= 2'h0;
                galt_reg <= '0;
                gdir_reg <= '0;
                gout_reg <= '0;
                prst_reg <= '0;
                gpe_reg <= 1'b0;
                imask_reg <= 4'h0;
                mbus_reg <= 2'h0;
            end else if (wr_ok) begin
                case (i_reg_addr)
                    `SWRSC_A_SWCTL: hold_bit_reg <= i_reg_wdata[`SWRSC_B_HOLD];
                    `SWRSC_A_ULSTS: ulsts_reg <= i_reg_wdata[0];
                    `SWRSC_A_DLSTS: dlsts_reg <= i_reg_wdata[NDS-1:0];
                    `SWRSC_A_WAKE: wake_reg <= i_reg_wdata[1:0];
                    `SWRSC_A_GALT: galt_reg <= i_reg_wdata[NGPIO-1:0];
                    `SWRSC_A_GDIR: gdir_reg <= i_reg_wdata[NGPIO-1:0];
                    `SWRSC_A_GOUT: gout_reg <= i_reg_wdata[NGPIO-1:0];
                    `SWRSC_A_PRST: prst_reg <= i_reg_wdata[NDS-1:0];
                    `SWRSC_A_GPE: gpe_reg <= i_reg_wdata[0];
                    `SWRSC_A_IMASK: imask_reg <= i_reg_wdata[3:0];
                    `SWRSC_A_MBUS: mbus_reg <= i_reg_wdata[1:0];
                    default: begin
                        // Unmapped or read-only: ignored
                    end
                endcase
            end
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            istat_reg <= 4'h0;
            exp_prev_reg <= 1'b0;
            wake_prev_reg <= 1'b0;
            apwr_prev_reg <= 1'b1;
        end else if (i_clk_en) begin
            exp_prev_reg <= exp_in;
            wake_prev_reg <= wake_in;
            apwr_prev_reg <= i_aux_power_disable_n;
            if (in_rst) begin
                istat_reg <= 4'h0;
            end else if (wr_ok && i_reg_addr == `SWRSC_A_ISTAT) begin
                istat_reg <= (istat_reg & ~i_reg_wdata[3:0]) | ev;
            end else begin
                istat_reg <= istat_reg | ev;
            end
        end
    end

    // Read port: data valid the cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_clk_en) begin
            o_reg_rdata <= 32'h0000_0000;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `SWRSC_A_SWCTL: o_reg_rdata[0] <= hold_bit_reg;
                    `SWRSC_A_ULSTS: o_reg_rdata[0] <= ulsts_reg;
                    `SWRSC_A_DLSTS: o_reg_rdata[NDS-1:0] <= dlsts_reg;
                    `SWRSC_A_WAKE: o_reg_rdata[1:0] <= wake_reg;
                    `SWRSC_A_GALT: o_reg_rdata[NGPIO-1:0] <= galt_reg;
                    `SWRSC_A_GDIR: o_reg_rdata[NGPIO-1:0] <= gdir_reg;
                    `SWRSC_A_GOUT: o_reg_rdata[NGPIO-1:0] <= gout_reg;
                    `SWRSC_A_GIN: o_reg_rdata[NGPIO-1:0] <= i_gpio;
                    `SWRSC_A_PRST: o_reg_rdata[NDS-1:0] <= prst_reg;
                    `SWRSC_A_GPE: o_reg_rdata[0] <= gpe_reg;
                    `SWRSC_A_ISTAT: o_reg_rdata[3:0] <= istat_reg;
                    `SWRSC_A_IMASK: o_reg_rdata[3:0] <= imask_reg;
                    `SWRSC_A_MBUS: o_reg_rdata[3:0] <= {i_mgmt_bus_data, i_mgmt_bus_clock, mbus_reg};
                    // Status: state, captured mode, hold strap
                    `SWRSC_A_STAT: o_reg_rdata[8:0] <= {hold_strap_reg, mode_reg, 1'b0, state_reg};
                    default: o_reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin drivers; pin outputs are all registered
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gpio <= '1;
            o_gpio_oe <= '0;
            o_wake_pin_n <= 1'b1;
            o_wake_pin_oe <= 1'b0;
            o_mgmt_bus_clock <= 1'b0;
            o_mgmt_bus_clock_oe <= 1'b0;
            o_mgmt_bus_data <= 1'b0;
            o_mgmt_bus_data_oe <= 1'b0;
        end else if (i_clk_en) begin
            // Plain role follows direction and data registers
            o_gpio <= gout_reg;
            o_gpio_oe <= gdir_reg & ~galt_reg;
            // Port resets held while core is in reset
            if (galt_reg[`SWRSC_G_P2]) begin
                o_gpio[`SWRSC_G_P2] <= ~(prst_reg[0] | ~state_reg[3]);
                o_gpio_oe[`SWRSC_G_P2] <= 1'b1;
            end
            if (galt_reg[`SWRSC_G_P4]) begin
                o_gpio[`SWRSC_G_P4] <= ~(prst_reg[2] | ~state_reg[3]);
                o_gpio_oe[`SWRSC_G_P4] <= 1'b1;
            end
            if (galt_reg[`SWRSC_G_P3]) begin
                o_gpio[`SWRSC_G_P3] <= ~(prst_reg[1] | ~state_reg[3]);
                o_gpio_oe[`SWRSC_G_P3] <= 1'b1;
            end
            // Expander line is an input: never driven
            if (galt_reg[`SWRSC_G_EXP]) begin
                o_gpio_oe[`SWRSC_G_EXP] <= 1'b0;
            end
            if (galt_reg[`SWRSC_G_GPE]) begin
                o_gpio[`SWRSC_G_GPE] <= ~gpe_reg;
                o_gpio_oe[`SWRSC_G_GPE] <= 1'b1;
            end
            // Wake driven only when direction says output
            o_wake_pin_oe <= wake_reg[`SWRSC_B_WDIR];
            o_wake_pin_n <= ~wake_reg[`SWRSC_B_WDRV];
            // Open-drain master pins, alive in hold too
            o_mgmt_bus_clock_oe <= mbus_reg[`SWRSC_B_MCLK] & ~state_reg[0];
            o_mgmt_bus_data_oe <= mbus_reg[`SWRSC_B_MDAT] & ~state_reg[0];
        end
    end

    // System outputs
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
            o_core_reset <= 1'b1;
            o_link_fund_reset <= 1'b1;
            o_aux_power_en <= 1'b0;
            o_pll_ref_valid <= 1'b0;
            o_eeprom_load_req <= 1'b0;
            o_mode_reserved <= 1'b0;
        end else if (i_clk_en) begin
            o_irq <= |(istat_reg & imask_reg);
            // Core stays in reset through init and hold
            o_core_reset <= ~state_reg[3];
            o_link_fund_reset <= state_reg[0] | state_reg[1];
            o_aux_power_en <= i_aux_power_disable_n;
            // Pair must be complementary to be a usable reference
            o_pll_ref_valid <= i_ref_clock_pos ^ i_ref_clock_neg;
            // Loader request pulses while init runs in mode 1
            o_eeprom_load_req <= state_reg[1] & (mode_reg == `SWRSC_MODE_EEP);
            o_mode_reserved <= (mode_reg != `SWRSC_MODE_NORM) && (mode_reg != `SWRSC_MODE_EEP);
        end
    end
endmodule
`default_nettype wire

// File: verif/swrsc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port watcher for the reset and strap sequencer
module swrsc_top_monitor #(
    parameter int RSTCYC = 25
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_fundamental_reset_n,
    input wire logic i_reset_hold_strap,
    input wire logic [2:0] i_operating_mode_straps,
    input wire logic i_aux_power_disable_n,
    input wire logic i_ref_clock_pos,
    input wire logic i_ref_clock_neg,
    input wire logic o_core_reset,
    input wire logic o_link_fund_reset,
    input wire logic o_aux_power_en,
    input wire logic o_pll_ref_valid,
    input wire logic o_eeprom_load_req,
    input wire logic o_mode_reserved
);
    // Run bound follows the reset procedure length, one cycle of margin
    localparam int RUN_MAX = RSTCYC + 4;
    // One domain for every property
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // Reset entry lands on state, then outputs
    property p_core_rst; !i_fundamental_reset_n |-> ##2 o_core_reset; endproperty
    a_core_rst: assert property (p_core_rst) else $error("core reset missed");
    property p_link_rst; !i_fundamental_reset_n |-> ##2 o_link_fund_reset; endproperty
    a_link_rst: assert property (p_link_rst) else $error("link reset missed");
    // Aux supply follows its disable pin; PLL valid follows the reference pair
    property p_aux; !i_aux_power_disable_n |=> !o_aux_power_en; endproperty
    a_aux: assert property (p_aux) else $error("aux power used");
    property p_pll; (i_ref_clock_pos ^ i_ref_clock_neg) |=> o_pll_ref_valid; endproperty
    a_pll: assert property (p_pll) else $error("ref clock ignored");
    // Mode decode from captured straps
    property p_eep; $rose(i_fundamental_reset_n) && i_operating_mode_straps == 3'h1 |-> ##[1:3] o_eeprom_load_req;
    endproperty
    a_eep: assert property (p_eep) else $error("eeprom load missing");
    property p_resv; $rose(i_fundamental_reset_n)
        |-> ##2 (o_mode_reserved == ($past(i_operating_mode_straps, 2) >= 3'h2)); endproperty
    a_resv: assert property (p_resv) else $error("reserved mode unflagged");
    // Hold strap keeps the core in reset; no hold means run
    property p_hold; $rose(i_fundamental_reset_n) && i_reset_hold_strap |-> o_core_reset [*5]; endproperty
    a_hold: assert property (p_hold) else $error("hold not kept");
    property p_run; $rose(i_fundamental_reset_n) && !i_reset_hold_strap |-> ##[2:RUN_MAX] !o_core_reset; endproperty
    a_run: assert property (p_run) else $error("run not reached");
endmodule
bind swrsc_top swrsc_top_monitor #(.RSTCYC(RSTCYC)) u_monitor (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_fundamental_reset_n(i_fundamental_reset_n), .i_reset_hold_strap(i_reset_hold_strap),
    .i_operating_mode_straps(i_operating_mode_straps), .i_aux_power_disable_n(i_aux_power_disable_n),
    .i_ref_clock_pos(i_ref_clock_pos), .i_ref_clock_neg(i_ref_clock_neg), .o_core_reset(o_core_reset),
    .o_link_fund_reset(o_link_fund_reset), .o_aux_power_en(o_aux_power_en), .o_pll_ref_valid(o_pll_ref_valid),
    .o_eeprom_load_req(o_eeprom_load_req), .o_mode_reserved(o_mode_reserved));
`default_nettype wire

// File: verif/swrsc_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board side: pull-ups, expander and wired pins
module swrsc_board (
    input wire logic [4:0] i_gpio_out,
    input wire logic [4:0] i_gpio_oe,
    input wire logic [4:0] i_pull_low,
    input wire logic i_wake_out,
    input wire logic i_wake_oe,
    input wire logic i_clk_oe,
    input wire logic i_dat_oe,
    output logic [4:0] o_gpio_pin,
    output logic o_wake_pin,
    output logic o_clk_pin,
    output logic o_dat_pin
);
    // Undriven pins float high; expander pulls low
    assign o_gpio_pin = (i_gpio_oe & i_gpio_out | ~i_gpio_oe) & ~i_pull_low;
    // Wake line idles deasserted
    assign o_wake_pin = i_wake_oe ? i_wake_out : 1'h1;
    // Open drain: only low is driven
    assign o_clk_pin = ~i_clk_oe;
    assign o_dat_pin = ~i_dat_oe;
endmodule
`default_nettype wire

// File: verif/swrsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module swrsc_top_tb;
    // Straps and pins, all valued at time zero
    logic clk = 1'h0, rst = 1'h1, frn = 1'h0, hold = 1'h1, us = 1'h1, apd = 1'h1, rp = 1'h0;
    logic rd = 1'h0, wr = 1'h0;
    // Clock enable and downstream strap, varied by the tests
    logic cen = 1'h1, ds = 1'h1;
    logic [2:0] mode = 3'h1;
    logic [11:0] addr = 12'h0;
    logic [31:0] wd = 32'h0, rdata, v;
    logic [4:0] gi, go, goe, pl = 5'h0;
    logic wi, wo, woe, ci, co, coe, di, dq, doe, irq, crst, lrst, aux, pll, eep, resv;
    int err_total = 0, checks_done = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    // Sim reset procedure cut to 2 cycles
    swrsc_top #(.RSTCYC(2)) DUT (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(cen),
        .i_fundamental_reset_n(frn), .i_reset_hold_strap(hold), .i_operating_mode_straps(mode),
        .i_downstream_common_clock_strap(ds), .i_upstream_common_clock_strap(us),
        .i_aux_power_disable_n(apd), .i_ref_clock_pos(rp), .i_ref_clock_neg(1'h0), .i_wake_pin_n(wi),
        .o_wake_pin_n(wo), .o_wake_pin_oe(woe), .i_gpio(gi), .o_gpio(go), .o_gpio_oe(goe),
        .i_mgmt_bus_clock(ci), .o_mgmt_bus_clock(co), .o_mgmt_bus_clock_oe(coe), .i_mgmt_bus_data(di),
        .o_mgmt_bus_data(dq), .o_mgmt_bus_data_oe(doe), .i_reg_addr(addr), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq), .o_core_reset(crst),
        .o_link_fund_reset(lrst), .o_aux_power_en(aux), .o_pll_ref_valid(pll),
        .o_eeprom_load_req(eep), .o_mode_reserved(resv));
    swrsc_board u_board (.i_gpio_out(go), .i_gpio_oe(goe), .i_pull_low(pl), .i_wake_out(wo),
        .i_wake_oe(woe), .i_clk_oe(coe), .i_dat_oe(doe), .o_gpio_pin(gi), .o_wake_pin(wi),
        .o_clk_pin(ci), .o_dat_pin(di));
    // Compare and tally
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 v = rdata;
    endtask
    // Bounded wait for core (1) or link (0) reset to reach a level
    task automatic wait_lvl(input logic core, input logic lvl);
        for (int k = 0; k < 60 && (core ? crst : lrst) !== lvl; k++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard, run needs about 80 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        frn <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk({eep, lrst}, 2'h3);
        wait_lvl(1'h0, 1'h0);
        chk(crst, 1'h1);
        rd_reg(12'h624);
        chk(v, 32'h124);
        rd_reg(12'h050);
        chk(v, 32'h1);
        rd_reg(12'h054);
        chk(v, 32'h7);
        wr_reg(12'h054, 32'h5);
        rd_reg(12'h054);
        chk(v, 32'h5);
        wr_reg(12'h5CC, 32'h3);
        rd_reg(12'h5CC);
        chk(v, 32'h3);
        chk({woe, wi}, 2'h2);
        wr_reg(12'h404, 32'h0);
        wait_lvl(1'h1, 1'h0);
        chk(crst, 1'h0);
        $display("hold release done");
        @(posedge clk);
        apd <= 1'h0;
        rp <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk({aux, pll}, 2'h1);
        rd_reg(12'h618);
        chk(v, 32'hA);
        wr_reg(12'h61C, 32'h1);
        wr_reg(12'h600, 32'h1F);
        wr_reg(12'h610, 32'h5);
        wr_reg(12'h614, 32'h1);
        @(posedge clk);
        #1;
        chk({goe, go[4], go[1:0], go[3]}, 9'h1B8);
        @(posedge clk);
        pl <= 5'h4;
        repeat (6) @(posedge clk);
        #1;
        chk(irq, 1'h1);
        wr_reg(12'h618, 32'hF);
        @(posedge clk);
        #1;
        chk(irq, 1'h0);
        wr_reg(12'h620, 32'h1);
        repeat (3) @(posedge clk);
        rd_reg(12'h620);
        chk(v[3:0], 4'h9);
        chk({coe, co, ci, doe, dq, di}, 6'h21);
        rd_reg(12'hFFC);
        chk(v, 32'h0);
        // Clock enable low freezes the aux output
        @(posedge clk);
        cen <= 1'h0;
        apd <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk(aux, 1'h0);
        @(posedge clk);
        cen <= 1'h1;
        @(posedge clk);
        #1;
        chk(aux, 1'h1);
        $display("pin functions done");
        @(posedge clk);
        frn <= 1'h0;
        hold <= 1'h0;
        mode <= 3'h0;
        ds <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
        chk({crst, lrst}, 2'h3);
        @(posedge clk);
        frn <= 1'h1;
        @(posedge clk);
        us <= 1'h0;
        wait_lvl(1'h1, 1'h0);
        chk({crst, resv, eep}, 3'h0);
        rd_reg(12'h050);
        chk(v, 32'h1);
        rd_reg(12'h054);
        chk(v, 32'h0);
        $display("mode and reset done");
        complete_run();
    end
endmodule
`default_nettype wire
